// File: rtl/dcbsc_pkg.sv
package dcbsc_pkg;

  // ---------------------------------------------------------------
  // Word and lane geometry
  // ---------------------------------------------------------------
  localparam int PIN_COUNT     = 24;                   // Parallel input pins, sampled on both edges.
  localparam int WORD_BITS     = 2 * PIN_COUNT;        // Full word assembled per input clock cycle.
  localparam int LANE_COUNT    = 8;                    // Serial data lanes.
  localparam int LANE_BITS     = WORD_BITS / LANE_COUNT; // Data bits carried by one lane per cycle.
  localparam int SLOT_COUNT    = LANE_BITS + 1;        // Serial slots per cycle, balance bit last.
  localparam int HIGH_HALF_POS = PIN_COUNT;            // Falling-edge half starts at this word bit.

  // ---------------------------------------------------------------
  // Disparity limits and reset values
  // ---------------------------------------------------------------
  localparam logic signed [3:0] RD_MAX   = 4'sh7;      // Upper saturation of the running disparity.
  localparam logic signed [3:0] RD_MIN   = -4'sh6;     // Lower saturation of the running disparity.
  localparam logic signed [3:0] RD_RESET = 4'sh0;      // Any value in range is legal; zero is used.
  localparam logic signed [4:0] DISP_OFS = 5'sh6;      // Disparity offset for a six-bit word.

  // ---------------------------------------------------------------
  // Forwarded clock lane
  // ---------------------------------------------------------------
  localparam logic [6:0] CLK_PATTERN = 7'h78;          // Four ones then three zeros, sent MSB first.

  // One lane word as it leaves the coder.
  typedef struct packed {
    logic                 balance_select;                         // Balance bit: high when the data is inverted.
    logic [LANE_BITS-1:0] data;                        // Data as sent, possibly inverted.
  } dcbsc_lane_t;

endpackage

// File: rtl/dcbsc_serializer.sv
`timescale 1ns/10ps
// How it works
// [R1] Rising half is bits 0-23, falling half 24-47.
// [R2] Host presents low half rising, high half falling.
// [R3] Balance off: lanes carry data unmodified, no bit; slot six is still sent here, held low.
// [R4] Balance coding only while balance select high.
// [R5] Balance on: extra bit, word true or inverted.
// [R6] Word disparity is ones minus zeros.
// [R7] Running disparity starts within minus six..seven.
// [R8] Add disparity minus one, or one minus it.
// [R9] Running disparity clamps at seven and minus six.
// [R10] Invert on zero, both positive, or negative/non-positive.
// [R11] Balance bit recomputed every cycle per lane.
// [R12] Balance bit high exactly when word inverted.
// [R13] Each lane keeps its own disparity and decision.
// [R14] Clock lane sends 1111000 framing each cycle.
module dcbsc_serializer
  import dcbsc_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  linkClk,
  input  wire logic [PIN_COUNT-1:0]  parallelInputPins,
  input  wire logic                  balanceSelect,
  output logic      [LANE_COUNT-1:0] serialData,
  output logic                       serialClk,
  output logic                       serialValid
);

  // ---------------------------------------------------------------
  // Link domain: double-edge capture
  // ---------------------------------------------------------------
  logic                  linkRst1_reg;
  logic                  linkRst2_reg;
  logic [PIN_COUNT-1:0]  lowHalf_reg;
  logic [WORD_BITS-1:0]  xferWord_reg;
  logic                  linkToggle_reg;

  // Reset is carried into the link domain through two flops; the first is read by nothing else.
  always_ff @(posedge linkClk) begin
    linkRst1_reg <= nrst;
    linkRst2_reg <= linkRst1_reg;
  end

  // The rising edge holds the lower half until its partner arrives on the falling edge.
  always_ff @(posedge linkClk) begin
    lowHalf_reg <= parallelInputPins; // [R1]
  end

  // The falling edge completes the word and flips the toggle that announces it to sys_clk.
  // The word stays frozen for a whole link period, far longer than the crossing takes.
  always_ff @(negedge linkClk) begin
    if (!linkRst2_reg) begin
      xferWord_reg   <= '0;
      linkToggle_reg <= 1'b0;
    end else begin
      xferWord_reg   <= {parallelInputPins, lowHalf_reg}; // [R1] [R2]
      linkToggle_reg <= ~linkToggle_reg;
    end
  end

  // ---------------------------------------------------------------
  // Crossing into sys_clk
  // ---------------------------------------------------------------
  logic tog1_reg;
  logic tog2_reg;
  logic tog3_reg;
  logic bal1_reg;
  logic bal2_reg;
  logic wordArrive;

  // Toggle and balance select each pass two flops before any logic looks at them.
  always_ff @(posedge sys_clk) begin
    tog1_reg <= linkToggle_reg;
    tog2_reg <= tog1_reg;
    tog3_reg <= tog2_reg;
    bal1_reg <= balanceSelect;
    bal2_reg <= bal1_reg;
  end

  assign wordArrive = tog2_reg ^ tog3_reg;

  // ---------------------------------------------------------------
  // Per-lane balance coding
  // ---------------------------------------------------------------
  // Ones minus zeros of a six-bit word.
  function automatic logic signed [4:0] lane_disp(input logic [LANE_BITS-1:0] w);
    logic [2:0] ones;
    ones = 3'h0;
    for (int k = 0; k < LANE_BITS; k++) begin
      ones = ones + {2'h0, w[k]};
    end
    return $signed({1'b0, ones, 1'b0}) - DISP_OFS; // [R6]
  endfunction

  // Adds the modified disparity and clamps instead of wrapping.
  function automatic logic signed [3:0] rd_sat(input logic signed [3:0] rd, input logic signed [4:0] m);
    logic signed [5:0] sum;
    sum = {{2{rd[3]}}, rd} + {m[4], m};
    // Limits are widened as signed values; an unsigned compare would clamp every negative sum high.
    if (sum > $signed({{2{RD_MAX[3]}}, RD_MAX})) begin
      return RD_MAX; // [R9]
    end
    if (sum < $signed({{2{RD_MIN[3]}}, RD_MIN})) begin
      return RD_MIN; // [R9]
    end
    return sum[3:0];
  endfunction

  logic signed [3:0]    rd_reg   [LANE_COUNT];
  logic signed [3:0]    rd_next  [LANE_COUNT];
  dcbsc_lane_t          laneEnc  [LANE_COUNT];
  dcbsc_lane_t          laneWord_reg [LANE_COUNT];
  logic signed [4:0]    laneDisp [LANE_COUNT];

  genvar gl;
  generate
    for (gl = 0; gl < LANE_COUNT; gl++) begin : g_lane
      logic [LANE_BITS-1:0] raw;
      logic                 rdPos;
      logic                 rdNeg;
      logic                 dPos;
      logic                 inv;
      logic signed [4:0]    modDisp;

      // Each lane owns a six-bit slice of the word and its own disparity state.
      assign raw          = xferWord_reg[gl*LANE_BITS +: LANE_BITS]; // [R13]
      assign laneDisp[gl] = lane_disp(raw);
      assign rdNeg        = rd_reg[gl][3];
      assign rdPos        = !rd_reg[gl][3] && (rd_reg[gl] != 4'sh0);
      assign dPos         = !laneDisp[gl][4] && (laneDisp[gl] != 5'sh0);
      // With balance on, zero running disparity always inverts; the decision is fresh for every word.
      assign inv          = bal2_reg &&
                            ((rd_reg[gl] == 4'sh0) || (rdPos && dPos) || (rdNeg && !dPos)); // [R4] [R10] [R11]
      assign modDisp      = inv ? (5'sh1 - laneDisp[gl]) : (laneDisp[gl] - 5'sh1); // [R8]
      // With balance off the accumulator is left alone, so re-enabling resumes from a legal value.
      assign rd_next[gl]  = bal2_reg ? rd_sat(rd_reg[gl], modDisp) : rd_reg[gl]; // [R4]
      assign laneEnc[gl].data = raw ^ {LANE_BITS{inv}}; // [R3] [R5]
      assign laneEnc[gl].balance_select  = inv; // [R12]

      // Running disparity and the coded word update once per arriving word.
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          rd_reg[gl]       <= RD_RESET; // [R7]
          laneWord_reg[gl] <= '0;
        end else if (wordArrive) begin
          rd_reg[gl]       <= rd_next[gl];
          laneWord_reg[gl] <= laneEnc[gl];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Slot sequencer and serial outputs
  // ---------------------------------------------------------------
  logic [2:0]            slot_reg;
  logic                  active_reg;
  logic                  balWord_reg;
  logic [LANE_COUNT-1:0] serialData_reg;
  logic                  serialClk_reg;
  logic                  serialValid_reg;
  logic [LANE_COUNT-1:0] slotBits;
  logic                  lastSlot;

  assign lastSlot = (slot_reg == 3'(SLOT_COUNT - 1));

  // Slot six is the balance bit; in plain mode it is held low but still sent, so every frame is seven slots.
  generate
    for (gl = 0; gl < LANE_COUNT; gl++) begin : g_slot
      assign slotBits[gl] = lastSlot ? (laneWord_reg[gl].balance_select && balWord_reg) // [R3] [R5]
                                     : laneWord_reg[gl].data[slot_reg];
    end
  endgenerate

  // A new word restarts the seven slots; a word arriving mid-frame cannot happen at the link rate.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slot_reg    <= 3'h0;
      active_reg  <= 1'b0;
      balWord_reg <= 1'b0;
    end else if (wordArrive) begin
      slot_reg    <= 3'h0;
      active_reg  <= 1'b1;
      balWord_reg <= bal2_reg;
    end else if (active_reg) begin
      slot_reg    <= lastSlot ? 3'h0 : slot_reg + 3'h1;
      active_reg  <= !lastSlot;
    end
  end

  // Outputs are registered; lanes and the clock lane idle low between frames.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      serialData_reg  <= '0;
      serialClk_reg   <= 1'b0;
      serialValid_reg <= 1'b0;
    end else begin
      serialData_reg  <= active_reg ? slotBits : '0;
      serialClk_reg   <= active_reg && CLK_PATTERN[3'(SLOT_COUNT - 1) - slot_reg]; // [R14]
      serialValid_reg <= active_reg;
    end
  end

  assign serialData  = serialData_reg;
  assign serialClk   = serialClk_reg;
  assign serialValid = serialValid_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic [LANE_BITS-1:0] raw0;
  int                   rdWant0;
  assign raw0 = xferWord_reg[LANE_BITS-1:0];

  // Unclamped lane 0 update in plain integers, kept apart from the saturating function it checks.
  assign rdWant0 = int'(rd_reg[0]) + (laneEnc[0].balance_select ? 1 - int'(laneDisp[0]) : int'(laneDisp[0]) - 1);

  a_rd_range_hold: assert property (rd_reg[0] <= RD_MAX && rd_reg[0] >= RD_MIN) // [R7] [R9]
    else $error("Lane 0 running disparity left its range.");

  a_plain_mode_data: assert property (wordArrive && !bal2_reg |=> // [R3]
      laneWord_reg[0].data == $past(raw0) && !laneWord_reg[0].balance_select)
    else $error("Plain mode altered lane 0 data.");

  a_bal_bit_inv: assert property (wordArrive |=> // [R5] [R12]
      laneWord_reg[0].data == ($past(raw0) ^ {LANE_BITS{laneWord_reg[0].balance_select}}))
    else $error("Balance bit does not match inversion.");

  a_zero_rd_inverts: assert property (wordArrive && bal2_reg && rd_reg[0] == 4'sh0 |=> // [R10]
      laneWord_reg[0].balance_select)
    else $error("Zero running disparity did not invert.");

  a_pos_neg_keeps: assert property (wordArrive && bal2_reg && !rd_reg[0][3] && rd_reg[0] != 4'sh0 // [R10]
      && laneDisp[0][4] |=> !laneWord_reg[0].balance_select)
    else $error("Positive disparity with negative word was inverted.");

  a_rd_update_sum: assert property (wordArrive && bal2_reg |=> // [R8] [R6]
      int'(rd_reg[0]) == (($past(rdWant0) > int'(RD_MAX)) ? int'(RD_MAX) :
                          ($past(rdWant0) < int'(RD_MIN)) ? int'(RD_MIN) : $past(rdWant0)))
    else $error("Running disparity update is wrong.");

  a_rd_frozen_off: assert property (wordArrive && !bal2_reg |=> $stable(rd_reg[0])) // [R4]
    else $error("Running disparity moved with balance off.");

  a_clk_lane_frame: assert property ($rose(serialValid) |-> serialClk[*4] ##1 (!serialClk)[*3]) // [R14]
    else $error("Clock lane pattern is not four high, three low.");

  a_frame_seven: assert property ($rose(serialValid) |-> serialValid[*7] ##1 !serialValid) // [R5]
    else $error("Frame is not seven slots long.");

  c_inverted_word: cover property (wordArrive && bal2_reg ##1 laneWord_reg[0].balance_select);
  c_plain_word:    cover property (wordArrive && !bal2_reg);
  c_rd_top:        cover property (rd_reg[0] == RD_MAX);
  c_rd_bottom:     cover property (rd_reg[0] == RD_MIN);

endmodule

// File: dv/dcbsc_host_model.sv
`timescale 1ns/10ps
// Host data source: the low half of each word stands before the link clock rise,
// the high half before the fall, both on the same pins.
module dcbsc_host_model
  import dcbsc_pkg::*;
(
  input  wire logic                 linkClk,
  input  wire logic [WORD_BITS-1:0] nextWord,
  output logic      [PIN_COUNT-1:0] pins
);
  logic [WORD_BITS-1:0] curWord;

  initial begin
    pins    = '0;
    curWord = '0;
  end

  // Pins change just after an edge, so each half holds across the edge that captures it.
  always @(negedge linkClk) begin
    curWord <= nextWord;
    pins    <= nextWord[PIN_COUNT-1:0];
  end

  always @(posedge linkClk) begin
    pins <= curWord[WORD_BITS-1:HIGH_HALF_POS];
  end
endmodule

// File: dv/dcbsc_serializer_tb.sv
`timescale 1ns/10ps
module dcbsc_serializer_tb
  import dcbsc_pkg::*;
;
  logic                  sys_clk;
  logic                  nrst;
  logic                  linkClk;
  logic                  balanceSelect;
  logic [PIN_COUNT-1:0]  pins;
  logic [WORD_BITS-1:0]  nextWord;
  logic [WORD_BITS-1:0]  word;
  logic [LANE_COUNT-1:0] serialData;
  logic                  serialClk;
  logic                  serialValid;
  logic [31:0]           seed;
  logic [WORD_BITS:0]    expQ[$];
  int                    rd[LANE_COUNT];
  int                    miscompares;
  int                    tests_run;

  // The link clock starts off phase so its edges never line up with the core clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    linkClk = 1'b0;
    #33;
    forever #80 linkClk = ~linkClk;
  end

  dcbsc_host_model u_dcbsc_host_model (.linkClk(linkClk), .nextWord(nextWord), .pins(pins));

  dcbsc_serializer u_dcbsc_serializer (
    .sys_clk          (sys_clk),
    .nrst             (nrst),
    .linkClk          (linkClk),
    .parallelInputPins(pins),
    .balanceSelect    (balanceSelect),
    .serialData       (serialData),
    .serialClk        (serialClk),
    .serialValid      (serialValid)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  // Expected slots of one lane, balance bit last; updates that lane's running disparity.
  function automatic logic [SLOT_COUNT-1:0] laneSlots(input int i, input logic [WORD_BITS:0] e);
    logic [LANE_BITS-1:0] d;
    int                   disp;
    logic                 inv;
    d    = e[LANE_BITS*i +: LANE_BITS];
    disp = 2 * $countones(d) - LANE_BITS;
    if (!e[WORD_BITS]) return {1'b0, d};
    inv   = (rd[i] == 0) || (rd[i] > 0 && disp > 0) || (rd[i] < 0 && disp <= 0);
    rd[i] = rd[i] + (inv ? 1 - disp : disp - 1);
    if (rd[i] > RD_MAX) rd[i] = RD_MAX;
    if (rd[i] < RD_MIN) rd[i] = RD_MIN;
    return {inv, inv ? ~d : d};
  endfunction

  task automatic check(input string what, input logic [SLOT_COUNT-1:0] exp, input logic [SLOT_COUNT-1:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Frame monitor: words not yet queued are the idle zero words sent in plain mode.
  initial begin : frame_monitor
    logic [SLOT_COUNT-1:0] got[LANE_COUNT];
    logic [WORD_BITS:0]    e;
    int                    n;
    @(posedge nrst);
    forever begin
      n = 0;
      while (serialValid !== 1'b1) begin
        @(negedge sys_clk);
        n++;
        if (n > 100) begin
          miscompares++;
          report_and_stop();
        end
      end
      e = (expQ.size() > 0) ? expQ.pop_front() : '0;
      for (int k = 0; k < SLOT_COUNT; k++) begin
        check("serialClk", SLOT_COUNT'(CLK_PATTERN[SLOT_COUNT-1-k]), SLOT_COUNT'(serialClk));
        check("serialValid", SLOT_COUNT'(1'b1), SLOT_COUNT'(serialValid));
        for (int i = 0; i < LANE_COUNT; i++) got[i][k] = serialData[i];
        @(negedge sys_clk);
      end
      check("serialValid end", SLOT_COUNT'(1'b0), SLOT_COUNT'(serialValid));
      for (int i = 0; i < LANE_COUNT; i++) begin
        check("lane slots", laneSlots(i, e), got[i]);
      end
    end
  end

  // Main sequence: corner words first (zeros reach the upper limit), then random words.
  initial begin
    nrst          = 1'b0;
    balanceSelect = 1'b0;
    nextWord      = '0;
    seed          = 32'h7322;
    miscompares   = 0;
    tests_run     = 0;
    for (int i = 0; i < LANE_COUNT; i++) rd[i] = 0;
    // Held long enough for three link clock rises, more than the two the link-side reset needs.
    repeat (50) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(posedge linkClk);
    for (int w = 0; w < 200; w++) begin
      if (w < 6) begin
        word = (w == 2 || w == 4) ? '1 : '0;
      end else begin
        seed       = lfsr(seed);
        word[31:0] = seed;
        seed       = lfsr(seed);
        word[47:32] = seed[15:0];
      end
      nextWord = word;
      @(negedge linkClk);
      @(posedge linkClk);
      @(negedge sys_clk);
      balanceSelect = (w < 6) ? (w < 5) : seed[20];
      expQ.push_back({balanceSelect, word});
    end
    // The link keeps capturing every cycle, so trailing words must match the idle zero plain frames.
    nextWord = '0;
    @(negedge linkClk);
    @(posedge linkClk);
    @(negedge sys_clk);
    balanceSelect = 1'b0;
    repeat (40) @(negedge sys_clk);
    report_and_stop();
  end
endmodule
